/* File: sllc_pkg.sv */
`default_nettype none
package sllc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ALIGN_CTRL_ADDR = 8'h20;
    localparam logic [7:0] SYNC_MODE_ADDR  = 8'h21;
    localparam logic [7:0] TEST_PAT_ADDR   = 8'h22;
    localparam logic [7:0] FRAME_CNT_ADDR  = 8'h26;
    localparam logic [7:0] PRBS_SEL_ADDR   = 8'h36;
    localparam logic [7:0] REG_RESET       = 8'h00;

    // ------------------------------------------------------------
    // alignment control fields
    // ------------------------------------------------------------
    localparam int FPM_OVERRIDE_BIT   = 7;
    localparam int OUT_MODE_WE_BIT    = 6;
    localparam int TRANSPORT_TEST_BIT = 4;
    localparam int LANE_MARKER_BIT    = 2;
    localparam int FRAME_MARKER_BIT   = 1;
    localparam int ILA_DISABLE_BIT    = 0;
    localparam logic [7:0] ALIGN_CTRL_MASK = 8'hd7;

    // ------------------------------------------------------------
    // sync and output mode fields
    // ------------------------------------------------------------
    localparam int SW_SYNC_REQ_BIT  = 7;
    localparam int SW_SYNC_SEL_BIT  = 6;
    localparam int SYNC_SHARE_BIT   = 5;
    localparam int OUT_MODE_LSB     = 0;
    localparam int OUT_MODE_W       = 2;
    localparam logic [7:0] SYNC_UPPER_MASK = 8'he0;

    // ------------------------------------------------------------
    // test pattern fields
    // ------------------------------------------------------------
    localparam int PATTERN_LSB      = 5;
    localparam int PATTERN_W        = 3;
    localparam int RPAT_DISP_BIT    = 4;
    localparam int LMFC_MASK_BIT    = 3;
    localparam logic [7:0] TEST_PAT_MASK = 8'hf8;
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_D215   = 3'h1;
    localparam logic [2:0] PAT_K285   = 3'h2;
    localparam logic [2:0] PAT_ILA    = 3'h3;
    localparam logic [2:0] PAT_RPAT   = 3'h4;
    localparam logic [2:0] PAT_PRBS   = 3'h6;

    // ------------------------------------------------------------
    // frame count and polynomial fields
    // ------------------------------------------------------------
    localparam int FRAME_CNT_W = 5;
    localparam logic [7:0] FRAME_CNT_MASK = 8'h1f;
    localparam logic [5:0] FRAMES_DEFAULT = 6'h05;
    localparam int PRBS_LSB = 6;
    localparam logic [7:0] PRBS_SEL_MASK  = 8'hc0;

    typedef enum logic [2:0] {
        SLLC_OUT_NORMAL,
        SLLC_OUT_D215,
        SLLC_OUT_K285,
        SLLC_OUT_ILA_REPEAT,
        SLLC_OUT_RPAT,
        SLLC_OUT_PRBS
    } sllc_pattern_t;

    typedef enum logic [1:0] {
        SLLC_PRBS7,
        SLLC_PRBS15,
        SLLC_PRBS23,
        SLLC_PRBS31
    } sllc_poly_t;

    typedef struct packed {
        logic [5:0]    frames_per_multiframe;
        logic [1:0]    lane_output_mode;
        logic          transport_test;
        logic          lane_marker;
        logic          frame_marker;
        logic          ila_enable;
        sllc_pattern_t pattern;
        sllc_poly_t    prbs_poly;
        logic          rpat_disp_flip;
        logic          lmfc_mask_clear;
        logic          sync_request;
        logic          force_k285;
    } sllc_cfg_t;

endpackage
`default_nettype wire

/* File: sllc_link_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - override clear gives five frames per multiframe; set uses programmed count.
// - programmed count is a 5-bit field; length used is field plus one.
// - host writes to lane output mode field take effect only while output-mode write enable is set.
// - transport test enable sends the long transport test pattern.
// - lane marker insert bit inserts K28.3 lane alignment characters.
// - frame marker insert bit inserts K28.7 frame alignment characters.
// - initial-alignment disable suppresses the alignment sequence after sync release.
// - software sync select takes sync request from register bit, not pin.
// - software select and request together force continuous K28.5 output.
// - share clear uses own sync pin; set uses other pair's pin.
// - lane output mode derived for modes 0,1,3,7; host programs 2,4,5,6.
// - link test pattern field selects normal, D21.5, K28.5, ILA repeat, RPAT, PRBS.
// - polynomial codes 0..3 mean PRBS7, PRBS15, PRBS23, PRBS31.
// - disparity flip acts only while pattern field equals RPAT.
// - multiframe clock mask clear bit resets the mask.
// - host registers reset to zero; cfg_q resets to five frames per multiframe with ila_enable set.
module sllc_link_ctrl #(
    parameter int PAIR_INDEX = 0                 // 0 first lane pair, 1 second
) (
    input  wire logic                clk,         // 25 MHz clock
    input  wire logic                reset_n,     // async reset, active low
    input  wire logic [7:0]          reg_addr,    // register address
    input  wire logic [7:0]          reg_wdata,   // write data
    input  wire logic                reg_wr,      // write strobe
    input  wire logic                reg_rd,      // read strobe
    input  wire logic [2:0]          jesd_mode,   // device output mode
    input  wire logic                sync_pin_first_pair_n,  // first pair sync, low requests
    input  wire logic                sync_pin_second_pair_n, // second pair sync, low requests
    output logic [7:0]               reg_rdata_q, // read data
    output sllc_pkg::sllc_cfg_t      cfg_q        // link layer controls
);

    // elaboration-time refusal of an unsupported pair index
    if (PAIR_INDEX < 0 || PAIR_INDEX > 1) begin : g_bad_pair
        $error("PAIR_INDEX must be 0 or 1");
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] align_q;
    logic [7:0] sync_q;
    logic [7:0] test_q;
    logic [4:0] frame_cnt_q;
    logic [1:0] prbs_q;
    logic [1:0] mode_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] offs);
        return a == offs;
    endfunction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            align_q     <= sllc_pkg::REG_RESET;
            sync_q      <= sllc_pkg::REG_RESET;
            test_q      <= sllc_pkg::REG_RESET;
            frame_cnt_q <= '0;
            prbs_q      <= '0;
        end else if (reg_wr) begin
            // reserved bits never stored
            if (hit(reg_addr, sllc_pkg::ALIGN_CTRL_ADDR)) begin
                align_q <= reg_wdata & sllc_pkg::ALIGN_CTRL_MASK;
            end
            if (hit(reg_addr, sllc_pkg::SYNC_MODE_ADDR)) begin
                sync_q <= reg_wdata & sllc_pkg::SYNC_UPPER_MASK;
            end
            if (hit(reg_addr, sllc_pkg::TEST_PAT_ADDR)) begin
                test_q <= reg_wdata & sllc_pkg::TEST_PAT_MASK;
            end
            if (hit(reg_addr, sllc_pkg::FRAME_CNT_ADDR)) begin
                frame_cnt_q <= reg_wdata[sllc_pkg::FRAME_CNT_W-1:0];
            end
            if (hit(reg_addr, sllc_pkg::PRBS_SEL_ADDR)) begin
                prbs_q <= reg_wdata[sllc_pkg::PRBS_LSB +: 2];
            end
        end
    end

    // ------------------------------------------------------------
    // lane output mode
    // ------------------------------------------------------------
    function automatic logic auto_mode(input logic [2:0] m);
        return m == 3'h0 || m == 3'h1 || m == 3'h3 || m == 3'h7;
    endfunction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= '0;
        end else if (auto_mode(jesd_mode)) begin
            mode_q <= jesd_mode[1:0];
        end else if (reg_wr && hit(reg_addr, sllc_pkg::SYNC_MODE_ADDR)
                     && align_q[sllc_pkg::OUT_MODE_WE_BIT]) begin
            mode_q <= reg_wdata[sllc_pkg::OUT_MODE_LSB +: sllc_pkg::OUT_MODE_W];
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // bits that may read back nonzero at an address
    function automatic logic [7:0] rd_mask(input logic [7:0] a);
        if (hit(a, sllc_pkg::ALIGN_CTRL_ADDR)) return sllc_pkg::ALIGN_CTRL_MASK;
        if (hit(a, sllc_pkg::SYNC_MODE_ADDR))  return sllc_pkg::SYNC_UPPER_MASK | 8'h03;
        if (hit(a, sllc_pkg::TEST_PAT_ADDR))   return sllc_pkg::TEST_PAT_MASK;
        if (hit(a, sllc_pkg::FRAME_CNT_ADDR))  return sllc_pkg::FRAME_CNT_MASK;
        if (hit(a, sllc_pkg::PRBS_SEL_ADDR))   return sllc_pkg::PRBS_SEL_MASK;
        return 8'h00;
    endfunction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= '0;
        end else if (reg_rd) begin
            unique case (1'b1)
                hit(reg_addr, sllc_pkg::ALIGN_CTRL_ADDR): reg_rdata_q <= align_q;
                hit(reg_addr, sllc_pkg::SYNC_MODE_ADDR):  reg_rdata_q <= sync_q | {6'h00, mode_q};
                hit(reg_addr, sllc_pkg::TEST_PAT_ADDR):   reg_rdata_q <= test_q;
                hit(reg_addr, sllc_pkg::FRAME_CNT_ADDR):  reg_rdata_q <= {3'h0, frame_cnt_q};
                hit(reg_addr, sllc_pkg::PRBS_SEL_ADDR):   reg_rdata_q <= {prbs_q, 6'h00};
                default:                                  reg_rdata_q <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sync pin filters
    // ------------------------------------------------------------
    logic [1:0] pin_raw;
    logic [1:0] pin_m1_q;
    logic [1:0] pin_m2_q;
    logic [1:0] pin_m3_q;
    logic [1:0] pin_f_q;

    assign pin_raw = {sync_pin_second_pair_n, sync_pin_first_pair_n};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_sync
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    pin_m1_q[i] <= 1'b1;
                    pin_m2_q[i] <= 1'b1;
                    pin_m3_q[i] <= 1'b1;
                    pin_f_q[i]  <= 1'b1;
                end else begin
                    pin_m1_q[i] <= pin_raw[i];
                    pin_m2_q[i] <= pin_m1_q[i];
                    pin_m3_q[i] <= pin_m2_q[i];
                    if (pin_m2_q[i] == pin_m3_q[i]) begin
                        pin_f_q[i] <= pin_m3_q[i];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // derived controls
    // ------------------------------------------------------------
    sllc_pkg::sllc_cfg_t cfg_d;
    logic                pin_sel_n;
    logic                sw_sel;
    logic                sw_req;
    logic [2:0]          pat;

    assign sw_sel = sync_q[sllc_pkg::SW_SYNC_SEL_BIT];
    assign sw_req = sync_q[sllc_pkg::SW_SYNC_REQ_BIT];
    assign pat    = test_q[sllc_pkg::PATTERN_LSB +: sllc_pkg::PATTERN_W];
    assign pin_sel_n = sync_q[sllc_pkg::SYNC_SHARE_BIT] ? pin_f_q[1-PAIR_INDEX]
                                                        : pin_f_q[PAIR_INDEX];

    always_comb begin
        cfg_d = '0;
        cfg_d.frames_per_multiframe = align_q[sllc_pkg::FPM_OVERRIDE_BIT]
            ? {1'b0, frame_cnt_q} + 6'h01
            : sllc_pkg::FRAMES_DEFAULT;
        cfg_d.lane_output_mode = mode_q;
        cfg_d.transport_test   = align_q[sllc_pkg::TRANSPORT_TEST_BIT];
        cfg_d.lane_marker      = align_q[sllc_pkg::LANE_MARKER_BIT];
        cfg_d.frame_marker     = align_q[sllc_pkg::FRAME_MARKER_BIT];
        cfg_d.ila_enable       = !align_q[sllc_pkg::ILA_DISABLE_BIT];
        unique case (pat)
            sllc_pkg::PAT_D215: cfg_d.pattern = sllc_pkg::SLLC_OUT_D215;
            sllc_pkg::PAT_K285: cfg_d.pattern = sllc_pkg::SLLC_OUT_K285;
            sllc_pkg::PAT_ILA:  cfg_d.pattern = sllc_pkg::SLLC_OUT_ILA_REPEAT;
            sllc_pkg::PAT_RPAT: cfg_d.pattern = sllc_pkg::SLLC_OUT_RPAT;
            sllc_pkg::PAT_PRBS: cfg_d.pattern = sllc_pkg::SLLC_OUT_PRBS;
            default:            cfg_d.pattern = sllc_pkg::SLLC_OUT_NORMAL;
        endcase
        cfg_d.prbs_poly = sllc_pkg::sllc_poly_t'(prbs_q);
        cfg_d.rpat_disp_flip = test_q[sllc_pkg::RPAT_DISP_BIT]
                               && pat == sllc_pkg::PAT_RPAT;
        cfg_d.lmfc_mask_clear = test_q[sllc_pkg::LMFC_MASK_BIT];
        cfg_d.sync_request = sw_sel ? sw_req : !pin_sel_n;
        cfg_d.force_k285   = sw_sel && sw_req;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= '0;
            cfg_q.frames_per_multiframe <= sllc_pkg::FRAMES_DEFAULT;
            cfg_q.ila_enable <= 1'b1;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_default_frames: assert property (!align_q[7] |=> cfg_q.frames_per_multiframe == 6'h05)
        else $error("default frame count wrong");
    a_prog_frames: assert property (align_q[7] |=> cfg_q.frames_per_multiframe == $past(frame_cnt_q) + 6'h01)
        else $error("programmed frame count wrong");
    a_mode_gate: assert property (reg_wr && reg_addr == 8'h21 && !align_q[6] && !auto_mode(jesd_mode) |=> mode_q == $past(mode_q))
        else $error("output mode changed without enable");
    a_sw_sync: assert property (sw_sel |=> cfg_q.sync_request == $past(sw_req))
        else $error("software sync not followed");
    a_force_k285: assert property (sw_sel && sw_req |=> cfg_q.force_k285 && cfg_q.sync_request)
        else $error("K28.5 not forced");
    a_pin_sync: assert property (!sw_sel && !sync_q[5] && $stable(sync_q) [*4] |-> cfg_q.sync_request == !$past(pin_f_q[PAIR_INDEX]))
        else $error("own pin sync wrong");
    a_undef_pattern: assert property ((pat == 3'h5 || pat == 3'h7) |=> cfg_q.pattern == sllc_pkg::SLLC_OUT_NORMAL)
        else $error("undefined pattern not normal");
    a_disp_gate: assert property (pat != 3'h4 |=> !cfg_q.rpat_disp_flip)
        else $error("disparity flip outside RPAT");
    a_reserved_zero: assert property (reg_rd |=> (reg_rdata_q & ~rd_mask($past(reg_addr))) == 8'h00)
        else $error("reserved bit read nonzero");
    a_ila_disable: assert property (align_q[0] |=> !cfg_q.ila_enable)
        else $error("alignment sequence not suppressed");

    c_prbs: cover property (cfg_q.pattern == sllc_pkg::SLLC_OUT_PRBS && cfg_q.prbs_poly == sllc_pkg::SLLC_PRBS31);
    c_share: cover property (sync_q[5] && cfg_q.sync_request);
    c_mode_write: cover property (reg_wr && reg_addr == 8'h21 && align_q[6] ##1 mode_q != 2'h0);

endmodule
`default_nettype wire

/* File: sllc_sync_partner.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// receiver side: requests sync on a pair's pin, after LAG+1 clocks
// ------------------------------------------------------------
module sllc_sync_partner #(
    parameter int LAG = 2                         // response delay select 0 to 7, giving 1 to 8 clocks
) (
    input  wire logic clk,                        // link clock
    input  wire logic reset_n,                    // async reset, active low
    input  wire logic lose_first,                 // first pair lost lock
    input  wire logic lose_second,                // second pair lost lock
    output logic      sync_pin_first_pair_n,      // first pair sync, low requests
    output logic      sync_pin_second_pair_n      // second pair sync, low requests
);
    logic [7:0] first_q;
    logic [7:0] second_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            first_q  <= 8'h00;
            second_q <= 8'h00;
        end else begin
            first_q  <= {first_q[6:0], lose_first};
            second_q <= {second_q[6:0], lose_second};
        end
    end

    // pins held high while in lock
    assign sync_pin_first_pair_n  = ~first_q[LAG];
    assign sync_pin_second_pair_n = ~second_q[LAG];
endmodule
`default_nettype wire

/* File: sllc_link_ctrl_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module sllc_link_ctrl_bench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] jesd_mode = 3'h2;
    logic lose_first = 1'b0;
    logic lose_second = 1'b0;
    logic pin_first_n;
    logic pin_second_n;
    logic [7:0] reg_rdata_q;
    sllc_pkg::sllc_cfg_t cfg_q;
    int error_cnt = 0;
    int cmp_count = 0;
    // address, write data, read back
    localparam logic [23:0] ROWS [6] = '{24'h20ffd7, 24'h21ffe3, 24'h22fff8,
                                         24'h26ff1f, 24'h36ffc0, 24'h30ff00};

    always #20 clk = ~clk;

    sllc_sync_partner sllc_sync_partner_inst (
        .clk(clk), .reset_n(reset_n), .lose_first(lose_first), .lose_second(lose_second),
        .sync_pin_first_pair_n(pin_first_n), .sync_pin_second_pair_n(pin_second_n));

    sllc_link_ctrl #(.PAIR_INDEX(0)) sllc_link_ctrl_inst (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .jesd_mode(jesd_mode),
        .sync_pin_first_pair_n(pin_first_n), .sync_pin_second_pair_n(pin_second_n),
        .reg_rdata_q(reg_rdata_q), .cfg_q(cfg_q));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1 reg_wr = 1'b0;
    endtask

    // write, then let the derived controls land
    task automatic ws(input logic [7:0] a, input logic [7:0] d);
        wr(a, d);
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        @(posedge clk);
        #1 chk("read data", reg_rdata_q, exp);
    endtask

    task automatic pin_wait;
        repeat (10) @(posedge clk);
        #1;
    endtask

    function automatic logic [7:0] pat_exp(input int code);
        case (code)
            1: return 8'(sllc_pkg::SLLC_OUT_D215);
            2: return 8'(sllc_pkg::SLLC_OUT_K285);
            3: return 8'(sllc_pkg::SLLC_OUT_ILA_REPEAT);
            4: return 8'(sllc_pkg::SLLC_OUT_RPAT);
            6: return 8'(sllc_pkg::SLLC_OUT_PRBS);
            default: return 8'h00;
        endcase
    endfunction

    task automatic final_report;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        final_report;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        #1 reset_n = 1'b1;
        chk("frames", {2'h0, cfg_q.frames_per_multiframe}, 8'h05);
        chk("ila", {7'h0, cfg_q.ila_enable}, 8'h01);
        rd_chk(8'h20, 8'h00);
        rd_chk(8'h21, 8'h00);
        rd_chk(8'h22, 8'h00);
        wr(8'h20, 8'h40);
        for (int i = 0; i < 6; i++) begin
            wr(ROWS[i][23:16], ROWS[i][15:8]);
            rd_chk(ROWS[i][23:16], ROWS[i][7:0]);
        end
        wr(8'h20, 8'h00);
        wr(8'h21, 8'h00);
        ws(8'h22, 8'h00);
        chk("mode kept", {6'h0, cfg_q.lane_output_mode}, 8'h03);
        ws(8'h21, 8'h02);
        chk("mode locked", {6'h0, cfg_q.lane_output_mode}, 8'h03);
        ws(8'h20, 8'h40);
        ws(8'h21, 8'h01);
        chk("mode set", {6'h0, cfg_q.lane_output_mode}, 8'h01);
        jesd_mode = 3'h7;
        pin_wait;
        chk("mode auto", {6'h0, cfg_q.lane_output_mode}, 8'h03);
        jesd_mode = 3'h2;
        ws(8'h26, 8'h0f);
        ws(8'h20, 8'h80);
        chk("frames", {2'h0, cfg_q.frames_per_multiframe}, 8'h10);
        ws(8'h26, 8'h1f);
        chk("frames", {2'h0, cfg_q.frames_per_multiframe}, 8'h20);
        ws(8'h20, 8'h17);
        chk("frames", {2'h0, cfg_q.frames_per_multiframe}, 8'h05);
        chk("ctl bits", {4'h0, cfg_q.transport_test, cfg_q.lane_marker, cfg_q.frame_marker,
            cfg_q.ila_enable}, 8'h0e);
        ws(8'h20, 8'h00);
        chk("ctl bits", {4'h0, cfg_q.transport_test, cfg_q.lane_marker, cfg_q.frame_marker,
            cfg_q.ila_enable}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            ws(8'h22, 8'(i << 5));
            chk("pattern", {5'h0, cfg_q.pattern}, pat_exp(i));
        end
        for (int p = 0; p < 4; p++) begin
            ws(8'h36, 8'(p << 6));
            chk("poly", {6'h0, cfg_q.prbs_poly}, 8'(p));
        end
        ws(8'h22, 8'h98);
        chk("flip lmfc", {6'h0, cfg_q.rpat_disp_flip, cfg_q.lmfc_mask_clear}, 8'h03);
        ws(8'h22, 8'h30);
        chk("flip lmfc", {6'h0, cfg_q.rpat_disp_flip, cfg_q.lmfc_mask_clear}, 8'h00);
        ws(8'h22, 8'h00);
        lose_first = 1'b1;
        pin_wait;
        chk("sync own", {7'h0, cfg_q.sync_request}, 8'h01);
        ws(8'h21, 8'h20);
        pin_wait;
        chk("sync shared", {7'h0, cfg_q.sync_request}, 8'h00);
        lose_second = 1'b1;
        lose_first = 1'b0;
        pin_wait;
        chk("sync shared", {7'h0, cfg_q.sync_request}, 8'h01);
        lose_second = 1'b0;
        lose_first = 1'b1;
        ws(8'h21, 8'h40);
        pin_wait;
        chk("sw sync", {6'h0, cfg_q.sync_request, cfg_q.force_k285}, 8'h00);
        ws(8'h21, 8'hc0);
        chk("sw sync", {6'h0, cfg_q.sync_request, cfg_q.force_k285}, 8'h03);
        ws(8'h21, 8'h80);
        chk("k285 off", {7'h0, cfg_q.force_k285}, 8'h00);
        @(posedge clk);
        #1 reset_n = 1'b0;
        @(posedge clk);
        #1 chk("reset", {7'h0, cfg_q.ila_enable}, 8'h01);
        chk("reset sync", {6'h0, cfg_q.sync_request, cfg_q.force_k285}, 8'h00);
        chk("reset mode", {6'h0, cfg_q.lane_output_mode}, 8'h00);
        reset_n = 1'b1;
        rd_chk(8'h21, 8'h00);
        rd_chk(8'h26, 8'h00);
        final_report;
    end
endmodule
`default_nettype wire
